//--- bench/serial_fram_i2c_target_addressing_test.sv
// Self-checking bench for the serial memory target
`timescale 1ns/1ps
module serial_fram_i2c_target_addressing_test;
	localparam logic [3:0] TYPE = 4'h9; // Arbitrary value
	logic        sys_clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        rst = 1'b1;
	logic        scl, m_pull, sda_o, oe_n, vld;
	logic        wp = 1'b0;
	logic        rdy = 1'b1;
	logic [1:0]  straps = 2'h0;
	logic [8:0]  addr;
	logic [7:0]  data;
	logic [16:0] got_q[$], exp_q[$];
	wire         sda_w;
	int          num_errors = 0;
	int          n_compared = 0;
	int          cycles = 0;

	always #12.5 sys_clk = ~sys_clk;
	// Link edges fall on whole ns, rising system edges on half ns: never together
	always #32 link_clk = ~link_clk;
	assign sda_w = !m_pull && (oe_n || sda_o);

	sfr_target #(.DEV_TYPE(TYPE)) i_sfr_target (
		.sys_clk_i(sys_clk), .rst_i(rst), .link_clk_i(link_clk), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(oe_n), .device_select_straps_i(straps),
		.wp_i(wp), .wr_mon_valid_o(vld), .wr_mon_ready_i(rdy), .wr_mon_addr_o(addr),
		.wr_mon_data_o(data)
	);
	sfr_master i_sfr_master (.scl_o(scl), .sda_pull_o(m_pull), .sda_i(sda_w));

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (!rst && vld === 1'b1 && rdy)
			got_q.push_back({addr, data});
		if (cycles == 60000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic final_report();
		if (num_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pins(input logic [1:0] s, input logic w, input logic r);
		@(posedge sys_clk);
		#2;
		straps = s;
		wp = w;
		rdy = r;
	endtask
	task automatic sel(input logic [7:0] b, input logic exp_ack);
		logic [7:0] rx;
		logic ack;
		i_sfr_master.start();
		i_sfr_master.xfer(b, 1'b1, rx, ack);
		cmp(17'(ack), 17'(exp_ack));
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d0, input int n, input logic keep);
		logic [7:0] rx;
		logic ack;
		sel({TYPE, straps, a[8], 1'b0}, 1'b0);
		i_sfr_master.xfer(a[7:0], 1'b1, rx, ack);
		cmp(17'(ack), 17'h0);
		for (int i = 0; i < n; i++) begin
			i_sfr_master.xfer(8'(d0 + i), 1'b1, rx, ack);
			cmp(17'(ack), 17'h0);
			if (keep)
				exp_q.push_back({9'(a + i), 8'(d0 + i)});
		end
		i_sfr_master.stop();
	endtask
	task automatic rd(input logic pg, input logic [7:0] d0, input int n);
		logic [7:0] rx;
		logic ack;
		sel({TYPE, straps, pg, 1'b1}, 1'b0);
		for (int i = 0; i < n; i++) begin
			i_sfr_master.xfer(8'hFF, i == n - 1, rx, ack);
			cmp(17'(rx), 17'(8'(d0 + i)));
		end
		i_sfr_master.stop();
	endtask
	task automatic chk_mon();
		repeat (40) @(posedge sys_clk);
		cmp(17'(got_q.size()), 17'(exp_q.size()));
		foreach (exp_q[i])
			if (i < got_q.size())
				cmp(got_q[i], exp_q[i]);
		got_q.delete();
		exp_q.delete();
	endtask

	task automatic t_select();
		for (int s = 0; s < 4; s++) begin
			pins(2'(s), 1'b0, 1'b1);
			for (int d = 0; d < 4; d++) begin
				sel({TYPE, 2'(d), 2'b00}, s != d);
				i_sfr_master.stop();
			end
		end
		sel({~TYPE, 2'h3, 2'b00}, 1'b1);
		i_sfr_master.stop();
	endtask
	// Consumer stalls: two words buffered, the third waits for space
	task automatic t_wrap();
		pins(2'h2, 1'b0, 1'b0);
		wr(9'h1FE, 8'h10, 3, 1'b1);
		wr(9'h1FE, 8'h00, 0, 1'b1);
		pins(2'h2, 1'b0, 1'b1);
		chk_mon();
		rd(1'b1, 8'h10, 3);
	endtask
	task automatic t_protect();
		logic [7:0] rx;
		logic ack;
		pins(2'h1, 1'b1, 1'b1);
		wr(9'h050, 8'h20, 2, 1'b0);
		sel({TYPE, 2'h1, 2'b00}, 1'b0);
		i_sfr_master.xfer(8'h60, 1'b1, rx, ack);
		i_sfr_master.xfer(8'h40, 1'b1, rx, ack);
		pins(2'h1, 1'b0, 1'b1);
		i_sfr_master.xfer(8'h41, 1'b1, rx, ack);
		i_sfr_master.xfer(8'h42, 1'b1, rx, ack);
		i_sfr_master.stop();
		exp_q.push_back(17'h06141);
		exp_q.push_back(17'h06242);
		chk_mon();
	endtask
	task automatic t_abort();
		logic [7:0] rx;
		logic ack;
		pins(2'h0, 1'b0, 1'b1);
		sel({TYPE, 2'h0, 2'b00}, 1'b0);
		i_sfr_master.xfer(8'h70, 1'b1, rx, ack);
		for (int i = 0; i < 5; i++) begin
			i_sfr_master.put_bit(1'b0, ack);
		end
		sel({TYPE, 2'h0, 2'b00}, 1'b0);
		i_sfr_master.xfer(8'h72, 1'b1, rx, ack);
		i_sfr_master.xfer(8'h55, 1'b1, rx, ack);
		i_sfr_master.stop();
		exp_q.push_back(17'h07255);
		chk_mon();
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		#2;
		rst = 1'b0;
		repeat (20) @(posedge sys_clk);
		t_select();
		t_wrap();
		t_protect();
		t_abort();
		final_report();
	end
endmodule

//--- bench/sfr_master.sv
// Behavioural two-wire bus master facing the target
`timescale 1ns/1ps
module sfr_master #(
	parameter int HALF_NS = 500
) (
	// Bus pins; pull high means SDA driven low
	output logic      scl_o,
	output logic      sda_pull_o,
	input  wire logic sda_i
);
	// Idle bus: SCL stands high, SDA released
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic start();
		sda_pull_o = 1'b0;
		#(HALF_NS / 2) scl_o = 1'b1;
		#(HALF_NS) sda_pull_o = 1'b1;
		#(HALF_NS) scl_o = 1'b0;
		#(HALF_NS / 2);
	endtask
	task automatic stop();
		sda_pull_o = 1'b1;
		#(HALF_NS / 2) scl_o = 1'b1;
		#(HALF_NS / 2) sda_pull_o = 1'b0;
		#(HALF_NS);
	endtask
	// Data moves only while SCL is low, sampled mid-high
	task automatic put_bit(input logic b, output logic r);
		sda_pull_o = !b;
		#(HALF_NS / 2) scl_o = 1'b1;
		#(HALF_NS / 2) r = sda_i;
		#(HALF_NS / 2) scl_o = 1'b0;
		#(HALF_NS / 2);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			put_bit(tx[i], rx[i]);
		end
		put_bit(ack_in, ack_out);
	endtask
endmodule

//--- bench/sfr_target_chk.sv
// Port-level assertions for the serial memory target
`timescale 1ns/1ps
module sfr_target_chk (
	// Clocks and reset
	input wire logic                       sys_clk_i,
	input wire logic                       rst_i,
	input wire logic                       link_clk_i,
	// Bus pins
	input wire logic                       scl_i,
	input wire logic                       sda_i,
	input wire logic                       sda_o,
	input wire logic                       sda_oe_n_o,
	// Straps and protect
	input wire logic [sfr_pkg::SEL_W-1:0]  device_select_straps_i,
	input wire logic                       wp_i,
	// Write monitor stream
	input wire logic                       wr_mon_valid_o,
	input wire logic                       wr_mon_ready_i,
	input wire logic [sfr_pkg::ADDR_W-1:0] wr_mon_addr_o,
	input wire logic [sfr_pkg::BYTE_W-1:0] wr_mon_data_o
);
	AST_SDA_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		sda_o == 1'b0) else $error("SDA level not low");
	// Reset crosses three link edges, so allow eleven system edges
	AST_RST_OE: assert property (@(posedge sys_clk_i)
		rst_i [*8] ##1 rst_i [*3] |-> sda_oe_n_o) else $error("SDA held in reset");
	AST_RST_VALID: assert property (@(posedge sys_clk_i)
		rst_i |=> !wr_mon_valid_o) else $error("Valid after reset");
	AST_PULL_ON_LOW: assert property (@(posedge link_clk_i) disable iff (rst_i)
		$fell(sda_oe_n_o) |-> !scl_i) else $error("SDA pulled with SCL high");
	AST_RELEASE_ON_LOW: assert property (@(posedge link_clk_i) disable iff (rst_i)
		$rose(sda_oe_n_o) |-> !scl_i) else $error("SDA released with SCL high");
	AST_OE_BOUNDED: assert property (@(posedge link_clk_i) disable iff (rst_i)
		$fell(sda_oe_n_o) |-> ##[1:200] sda_oe_n_o) else $error("SDA held low too long");
	AST_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wr_mon_valid_o && !wr_mon_ready_i |=> wr_mon_valid_o && $stable(wr_mon_addr_o)
		&& $stable(wr_mon_data_o)) else $error("Stalled word changed");
	AST_WP_BLOCK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(wr_mon_valid_o) |-> !$past(wp_i, 16)) else $error("Write under protection");
endmodule

bind sfr_target sfr_target_chk i_sfr_target_chk (
	.sys_clk_i, .rst_i, .link_clk_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o,
	.device_select_straps_i, .wp_i, .wr_mon_valid_o, .wr_mon_ready_i,
	.wr_mon_addr_o, .wr_mon_data_o
);

//--- hdl/sfr_fifo2.sv
// Small valid/ready buffer, two entries by default
`timescale 1ns/1ps
module sfr_fifo2 #(
	parameter int unsigned W     = 17,
	parameter int unsigned DEPTH = 2
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Filling side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Draining side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);

	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [CW-1:0]           cnt;
	} sfr_fifo_s;

	sfr_fifo_s f_q;
	sfr_fifo_s f_d;
	logic      push;
	logic      pop;

	assign in_ready_o  = (f_q.cnt != CNT_FULL);
	assign out_valid_o = (f_q.cnt != '0);
	assign out_data_o  = f_q.mem[f_q.rp];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_comb begin
		f_d = f_q;
		if (push) begin
			f_d.mem[f_q.wp] = in_data_i;
			f_d.wp = (f_q.wp == PTR_LAST) ? '0 : PW'(f_q.wp + 1'b1);
		end
		if (pop) begin
			f_d.rp = (f_q.rp == PTR_LAST) ? '0 : PW'(f_q.rp + 1'b1);
		end
		if (push && !pop) begin
			f_d.cnt = CW'(f_q.cnt + 1'b1);
		end else if (pop && !push) begin
			f_d.cnt = CW'(f_q.cnt - 1'b1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
	end

endmodule

//--- hdl/sfr_pkg.sv
// Shared constants and types of the serial ferroelectric memory target
package sfr_pkg;

	// Array geometry
	localparam int unsigned ADDR_W    = 9;
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned MEM_WORDS = 512;
	localparam int unsigned PAGE_BIT  = 8;

	// Target address byte layout
	localparam int unsigned SA_RW_BIT   = 0;
	localparam int unsigned SA_PAGE_BIT = 1;
	localparam int unsigned SA_SEL_LO   = 2;
	localparam int unsigned SEL_W       = 2;
	localparam int unsigned SA_TYPE_LO  = 4;
	localparam int unsigned TYPE_W      = 4;

	// Bit counting within a byte
	localparam logic [3:0] CNT_ZERO  = 4'h0;
	localparam logic [3:0] CNT_ONE   = 4'h1;
	localparam logic [3:0] CNT_LAST  = 4'h7;
	localparam logic [3:0] CNT_FULL  = 4'h8;

	// Reset values and address step
	localparam logic             SDA_RELEASED = 1'b1;
	localparam logic [ADDR_W-1:0] ADDR_RST    = 9'h000;
	localparam logic [ADDR_W-1:0] ADDR_STEP   = 9'h001;
	localparam logic [BYTE_W-1:0] BYTE_RST    = 8'h00;

	// Bus timing served (kHz); link clock must run well above the top rate
	localparam int unsigned SCL_STD_KHZ  = 100;
	localparam int unsigned SCL_FAST_KHZ = 400;
	localparam int unsigned SCL_MAX_KHZ  = 1000;

	// Synchroniser depth
	localparam int unsigned SYNC_STAGES = 2;

	// Link state machine
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_MACK = 5'h10
	} sfr_state_e;

	// Which byte the receiver is collecting
	typedef enum logic [1:0] {
		KIND_SADDR = 2'h0,
		KIND_WORD  = 2'h1,
		KIND_DATA  = 2'h2
	} sfr_kind_e;

endpackage

//--- hdl/sfr_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module sfr_sync #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Level in and out
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sfr_sync_s;

	sfr_sync_s s_q;
	sfr_sync_s s_d;

	// First stage feeds only the second
	always_comb begin
		s_d      = s_q;
		s_d.meta = d_i;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.sync;

endmodule

//--- hdl/sfr_target.sv
// Two-wire serial target in front of a 512 x 8 byte array
// How it works
// - 512 byte locations, each picked by one 9-bit address.
// - Address is page bit on top of an 8-bit word address.
// - Answer only when select field equals the select straps.
// - Open select straps read low through pad pull-downs.
// - Sample on SCL rise, change outgoing bits on SCL fall.
// - Write protect high blocks every write; low blocks none of them.
// - Open write-protect reads low, so writes stay enabled.
// - SDA is only pulled low or released, never driven high.
// - Each received data byte is stored once complete, unless write protect is high or it still waits behind a full monitor buffer when the next byte completes.
// - No busy time; a new transaction is accepted immediately.
// - Serves 100 kHz, 400 kHz and up to 1 MHz clocks.
// - Only the power-on reset initialises the interface.
// - Address byte: select bits 3-2, page bit 1, direction bit 0.
// - Address steps after each data byte, wraps from top to zero.
// - Reads send from the held address until the master declines.
// - Start or stop aborts; start readies a new operation.
`timescale 1ns/1ps
module sfr_target #(
	parameter logic [sfr_pkg::TYPE_W-1:0] DEV_TYPE = 4'h5 // Arbitrary value
) (
	// System clock and power-on reset
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_i,
	// Link oversampling clock
	input  wire logic                       link_clk_i,
	// Serial bus pins
	input  wire logic                       scl_i,
	input  wire logic                       sda_i,
	output logic                            sda_o,
	output logic                            sda_oe_n_o,
	// Strap and protect pins
	input  wire logic [sfr_pkg::SEL_W-1:0]  device_select_straps_i,
	input  wire logic                       wp_i,
	// Stream of committed writes
	output logic                            wr_mon_valid_o,
	input  wire logic                       wr_mon_ready_i,
	output logic [sfr_pkg::ADDR_W-1:0]      wr_mon_addr_o,
	output logic [sfr_pkg::BYTE_W-1:0]      wr_mon_data_o
);

	localparam int unsigned PIN_W = sfr_pkg::SEL_W + 3;
	localparam int unsigned MON_W = sfr_pkg::ADDR_W + sfr_pkg::BYTE_W;

	// Link domain state
	typedef struct packed {
		sfr_pkg::sfr_state_e          st;
		sfr_pkg::sfr_kind_e           kind;
		logic [3:0]                   cnt;
		logic [sfr_pkg::BYTE_W-1:0]   sh;
		logic [sfr_pkg::BYTE_W-1:0]   tx;
		logic [sfr_pkg::ADDR_W-1:0]   addr;
		logic                         page;
		logic                         rw;
		logic                         oe_n;
		logic                         scl_p;
		logic                         sda_p;
		logic                         ack_p;
		logic                         want;
		logic [sfr_pkg::ADDR_W-1:0]   nxt_addr;
		logic [sfr_pkg::BYTE_W-1:0]   nxt_data;
		logic                         nxt_we;
		logic                         req_tgl;
		logic [sfr_pkg::ADDR_W-1:0]   req_addr;
		logic [sfr_pkg::BYTE_W-1:0]   req_data;
		logic                         req_we;
		logic [sfr_pkg::BYTE_W-1:0]   rd_byte;
	} sfr_link_s;

	// System domain state
	typedef struct packed {
		logic                         ack_tgl;
		logic [sfr_pkg::BYTE_W-1:0]   rdata;
	} sfr_sys_s;

	sfr_link_s                    l_q;
	sfr_link_s                    l_d;
	sfr_sys_s                     s_q;
	sfr_sys_s                     s_d;
	logic [sfr_pkg::BYTE_W-1:0]   mem [sfr_pkg::MEM_WORDS];

	logic                         link_rst;
	logic [PIN_W-1:0]             pins_s;
	logic                         scl_s;
	logic                         sda_s;
	logic [sfr_pkg::SEL_W-1:0]    sel_s;
	logic                         wp_s;
	logic                         ack_s;
	logic                         req_s;
	logic                         scl_rise;
	logic                         scl_fall;
	logic                         start_c;
	logic                         stop_c;
	logic                         busy;
	logic [sfr_pkg::BYTE_W-1:0]   rx_byte;
	logic                         mem_we;
	logic                         mon_in_valid;
	logic                         mon_in_ready;
	logic [MON_W-1:0]             mon_out;

	// Power-on reset carried into the link domain
	sfr_sync #(
		.W (1)
	) u_rst_sync (
		.clk_i (link_clk_i),
		.rst_i (1'b0),
		.d_i   (rst_i),
		.q_o   (link_rst)
	);

	// Pins pass two flops; left unreset so no false SCL edge follows reset
	sfr_sync #(
		.W (PIN_W)
	) u_pin_sync (
		.clk_i (link_clk_i),
		.rst_i (1'b0),
		.d_i   ({wp_i, device_select_straps_i, sda_i, scl_i}),
		.q_o   (pins_s)
	);

	// Answer toggle back into the link domain
	sfr_sync #(
		.W (1)
	) u_ack_sync (
		.clk_i (link_clk_i),
		.rst_i (link_rst),
		.d_i   (s_q.ack_tgl),
		.q_o   (ack_s)
	);

	// Request toggle into the system domain
	sfr_sync #(
		.W (1)
	) u_req_sync (
		.clk_i (sys_clk_i),
		.rst_i (rst_i),
		.d_i   (l_q.req_tgl),
		.q_o   (req_s)
	);

	// Pad pull-downs turn floating straps and protect into zeros
	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign sel_s = pins_s[sfr_pkg::SEL_W+1:2];
	assign wp_s  = pins_s[PIN_W-1];

	// Open drain: the data level is always low
	assign sda_o      = 1'b0;
	assign sda_oe_n_o = l_q.oe_n;

	// Bus events from the synchronised pins
	assign scl_rise = scl_s & ~l_q.scl_p;
	assign scl_fall = ~scl_s & l_q.scl_p;
	assign start_c  = scl_s & l_q.scl_p & l_q.sda_p & ~sda_s;
	assign stop_c   = scl_s & l_q.scl_p & ~l_q.sda_p & sda_s;
	assign busy     = l_q.req_tgl ^ ack_s;
	assign rx_byte  = {l_q.sh[sfr_pkg::BYTE_W-2:0], sda_s};

	// Link side: bit engine and memory requests
	always_comb begin
		l_d       = l_q;
		l_d.scl_p = scl_s;
		l_d.sda_p = sda_s;
		l_d.ack_p = ack_s;

		// Read data is stable in the other domain once its answer toggles
		if ((ack_s != l_q.ack_p) && !l_q.req_we) begin
			l_d.rd_byte = s_q.rdata;
		end

		// Fields stay frozen while a request is outstanding
		if (l_q.want && !busy) begin
			l_d.want     = 1'b0;
			l_d.req_tgl  = ~l_q.req_tgl;
			l_d.req_addr = l_q.nxt_addr;
			l_d.req_data = l_q.nxt_data;
			l_d.req_we   = l_q.nxt_we;
		end

		if (start_c) begin
			l_d.st   = sfr_pkg::ST_RX;
			l_d.kind = sfr_pkg::KIND_SADDR;
			l_d.cnt  = sfr_pkg::CNT_ZERO;
			l_d.oe_n = sfr_pkg::SDA_RELEASED;
		end else if (stop_c) begin
			l_d.st   = sfr_pkg::ST_IDLE;
			l_d.oe_n = sfr_pkg::SDA_RELEASED;
		end else begin
			case (l_q.st)
				sfr_pkg::ST_IDLE: begin
					l_d.oe_n = sfr_pkg::SDA_RELEASED;
				end
				sfr_pkg::ST_RX: begin
					if (scl_rise && (l_q.cnt != sfr_pkg::CNT_FULL)) begin
						l_d.sh  = rx_byte;
						l_d.cnt = l_q.cnt + sfr_pkg::CNT_ONE;
						if (l_q.cnt == sfr_pkg::CNT_LAST) begin
							case (l_q.kind)
								sfr_pkg::KIND_SADDR: begin
									if ((rx_byte[sfr_pkg::SA_TYPE_LO +: sfr_pkg::TYPE_W]
										== DEV_TYPE) &&
										(rx_byte[sfr_pkg::SA_SEL_LO +: sfr_pkg::SEL_W]
										== sel_s)) begin
										l_d.rw   = rx_byte[sfr_pkg::SA_RW_BIT];
										l_d.page = rx_byte[sfr_pkg::SA_PAGE_BIT];
										l_d.kind = sfr_pkg::KIND_WORD;
										if (rx_byte[sfr_pkg::SA_RW_BIT]) begin
											// Page from the address byte, word from the latch
											l_d.addr = {rx_byte[sfr_pkg::SA_PAGE_BIT],
												l_q.addr[sfr_pkg::PAGE_BIT-1:0]};
											l_d.want     = 1'b1;
											l_d.nxt_we   = 1'b0;
											l_d.nxt_data = sfr_pkg::BYTE_RST;
											l_d.nxt_addr = {rx_byte[sfr_pkg::SA_PAGE_BIT],
												l_q.addr[sfr_pkg::PAGE_BIT-1:0]};
										end
									end else begin
										l_d.st = sfr_pkg::ST_IDLE;
									end
								end
								sfr_pkg::KIND_WORD: begin
									l_d.addr = {l_q.page, rx_byte};
									l_d.kind = sfr_pkg::KIND_DATA;
								end
								sfr_pkg::KIND_DATA: begin
									// Protect level is looked at only here
									if (!wp_s) begin
										l_d.want     = 1'b1;
										l_d.nxt_we   = 1'b1;
										l_d.nxt_addr = l_q.addr;
										l_d.nxt_data = rx_byte;
									end
									l_d.addr = l_q.addr + sfr_pkg::ADDR_STEP;
								end
								default: begin
									l_d.st = sfr_pkg::ST_IDLE;
								end
							endcase
						end
					end else if (scl_fall && (l_q.cnt == sfr_pkg::CNT_FULL)) begin
						// Always ready, so every matched byte is acknowledged
						l_d.oe_n = 1'b0;
						l_d.st   = sfr_pkg::ST_ACK;
					end
				end
				sfr_pkg::ST_ACK: begin
					if (scl_fall) begin
						if (l_q.rw) begin
							l_d.st   = sfr_pkg::ST_TX;
							l_d.tx   = l_q.rd_byte;
							l_d.oe_n = l_q.rd_byte[sfr_pkg::BYTE_W-1];
							l_d.cnt  = sfr_pkg::CNT_ONE;
						end else begin
							l_d.st   = sfr_pkg::ST_RX;
							l_d.oe_n = sfr_pkg::SDA_RELEASED;
							l_d.cnt  = sfr_pkg::CNT_ZERO;
						end
					end
				end
				sfr_pkg::ST_TX: begin
					if (scl_fall) begin
						if (l_q.cnt == sfr_pkg::CNT_FULL) begin
							// Step and fetch ahead while the master answers
							l_d.oe_n     = sfr_pkg::SDA_RELEASED;
							l_d.st       = sfr_pkg::ST_MACK;
							l_d.cnt      = sfr_pkg::CNT_ZERO;
							l_d.addr     = l_q.addr + sfr_pkg::ADDR_STEP;
							l_d.want     = 1'b1;
							l_d.nxt_we   = 1'b0;
							l_d.nxt_data = sfr_pkg::BYTE_RST;
							l_d.nxt_addr = l_q.addr + sfr_pkg::ADDR_STEP;
						end else begin
							l_d.tx   = {l_q.tx[sfr_pkg::BYTE_W-2:0], 1'b0};
							l_d.oe_n = l_q.tx[sfr_pkg::BYTE_W-2];
							l_d.cnt  = l_q.cnt + sfr_pkg::CNT_ONE;
						end
					end
				end
				sfr_pkg::ST_MACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							l_d.st = sfr_pkg::ST_IDLE;
						end else begin
							l_d.cnt = sfr_pkg::CNT_ONE;
						end
					end else if (scl_fall && (l_q.cnt == sfr_pkg::CNT_ONE)) begin
						l_d.st   = sfr_pkg::ST_TX;
						l_d.tx   = l_q.rd_byte;
						l_d.oe_n = l_q.rd_byte[sfr_pkg::BYTE_W-1];
						l_d.cnt  = sfr_pkg::CNT_ONE;
					end
				end
				default: begin
					l_d.st   = sfr_pkg::ST_IDLE;
					l_d.oe_n = sfr_pkg::SDA_RELEASED;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			l_q       <= '0;
			l_q.st    <= sfr_pkg::ST_IDLE;
			l_q.kind  <= sfr_pkg::KIND_SADDR;
			l_q.oe_n  <= sfr_pkg::SDA_RELEASED;
			l_q.scl_p <= 1'b1;
			l_q.sda_p <= 1'b1;
			l_q.addr  <= sfr_pkg::ADDR_RST;
		end else begin
			l_q <= l_d;
		end
	end

	// System side: array access; a full monitor buffer holds the answer back
	always_comb begin
		s_d          = s_q;
		mem_we       = 1'b0;
		mon_in_valid = 1'b0;
		if (req_s != s_q.ack_tgl) begin
			if (l_q.req_we) begin
				mon_in_valid = 1'b1;
				if (mon_in_ready) begin
					mem_we      = 1'b1;
					s_d.ack_tgl = ~s_q.ack_tgl;
				end
			end else begin
				s_d.rdata   = mem[l_q.req_addr];
				s_d.ack_tgl = ~s_q.ack_tgl;
			end
		end
	end

	// Array is not reset: contents survive like the nonvolatile cells
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
		if (mem_we) begin
			mem[l_q.req_addr] <= l_q.req_data;
		end
	end

	sfr_fifo2 #(
		.W     (MON_W),
		.DEPTH (2)
	) u_mon_fifo (
		.clk_i       (sys_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (mon_in_valid),
		.in_ready_o  (mon_in_ready),
		.in_data_i   ({l_q.req_addr, l_q.req_data}),
		.out_valid_o (wr_mon_valid_o),
		.out_ready_i (wr_mon_ready_i),
		.out_data_o  (mon_out)
	);

	assign wr_mon_addr_o = mon_out[MON_W-1:sfr_pkg::BYTE_W];
	assign wr_mon_data_o = mon_out[sfr_pkg::BYTE_W-1:0];

endmodule
